// >>> hw/shrp_defs.svh
// Constants shared by the serial host register port files.
// Assumes inclusion by bare name from hw/.
`ifndef SHRP_DEFS_SVH
`define SHRP_DEFS_SVH

`define SHRP_ADDR_BITS     8
`define SHRP_BYTE_BITS     8
`define SHRP_WCODE_BITS    2
`define SHRP_CNT_BITS      6
`define SHRP_CLK_MHZ       100
`define SHRP_WR_LATENCY_US 60
`define SHRP_SYNC_CYCLES   4
`define SHRP_NUM_XING      3
`define SHRP_XING_WR       0
`define SHRP_XING_CMD      1
`define SHRP_XING_RD       2
`define SHRP_MAP_RESET     256'h0

`endif

// >>> hw/shrp_pkg.sv
// Types shared by the serial host register port files.
// Assumes nothing of its surroundings.
package shrp_pkg;

    typedef enum logic [1:0] {
        SHRP_PH_ADDR,
        SHRP_PH_WRITE,
        SHRP_PH_READ,
        SHRP_PH_DONE
    } shrp_phase_t;

endpackage

// >>> hw/shrp_xing_if.sv
// Event crossing bundle between the link and core clock domains.
// Assumes the toggles come from the link domain and the pulses feed the core.
`timescale 1ns/1ps
`default_nettype none

interface shrp_xing_if #(parameter int N = 3);
    logic [N-1:0] tgl;
    logic [N-1:0] pulse;

    modport src (output tgl, input pulse);
    modport sync (input tgl, output pulse);
endinterface

`default_nettype wire

// >>> hw/shrp_tsync.sv
// Toggle to pulse synchronisers, one per crossing event.
// Assumes clk is the core clock and the toggles come from another domain.
`timescale 1ns/1ps
`default_nettype none

module shrp_tsync
    import shrp_pkg::*;
#(
    parameter int N = 3
) (
    input  wire logic clk,
    input  wire logic rst,
    shrp_xing_if.sync xing
);

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
    } shrp_tsync_t;

    shrp_tsync_t st_reg;
    shrp_tsync_t st_next;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = xing.tgl;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // First stage feeds only the second; edge taken between later stages
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            assign xing.pulse[i] = st_reg.s2[i] ^ st_reg.s3[i];
        end
    endgenerate

endmodule

`default_nettype wire

// >>> hw/shrp_port.sv
// Serial host register port: link side shifter and core side register access.
// Assumes link_sclk comes from the host, clk is the 100 MHz core clock,
// and the user side answers a read strobe in the same cycle.
//
// Summary of operation
// - Single transfer: address byte, then optional one write or one read word.
// - Streaming registers accept one address then any number of words per frame.
// - Word width is whole bytes, chosen per register by the width map.
// - Address-only registers raise a command strobe with no data phase.
// - Command data is sampled on the rising serial clock edge.
// - Reply bits change on falling edges, a word's first bit when the hold word loads; stable while serial clock is high.
// - Written data reaches the core well inside sixty microseconds.
// - Interrupt asserts only for sources whose mask bit is set.
`timescale 1ns/1ps
`default_nettype none
`include "shrp_defs.svh"

module shrp_port
    import shrp_pkg::*;
#(
    parameter int       MAX_BYTES      = 4,
    parameter int       NUM_IRQ        = 8,
    parameter int       WR_LATENCY_CYC = `SHRP_WR_LATENCY_US * `SHRP_CLK_MHZ,
    parameter bit [255:0] RD_MAP       = `SHRP_MAP_RESET,
    parameter bit [255:0] CMD_MAP      = `SHRP_MAP_RESET,
    parameter bit [255:0] STREAM_MAP   = `SHRP_MAP_RESET,
    parameter bit [511:0] WIDTH_MAP    = {`SHRP_MAP_RESET, `SHRP_MAP_RESET}
) (
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              link_sclk,
    input  wire logic                              select_n,
    input  wire logic                              command_data_in,
    output logic                                   reply_data_out,
    output logic                                   reply_data_oe,
    output logic                                   irq_n_out,
    output logic                                   irq_n_oe,
    output logic [`SHRP_ADDR_BITS-1:0]             reg_addr,
    output logic [`SHRP_WCODE_BITS-1:0]            reg_bytes_m1,
    output logic [MAX_BYTES*`SHRP_BYTE_BITS-1:0]   wr_data,
    output logic                                   wr_strobe,
    output logic                                   cmd_strobe,
    output logic                                   rd_strobe,
    input  wire logic [MAX_BYTES*`SHRP_BYTE_BITS-1:0] rd_data,
    input  wire logic [NUM_IRQ-1:0]                irq_sources,
    input  wire logic [NUM_IRQ-1:0]                irq_mask,
    output logic                                   frame_active,
    output logic                                   frame_end
);

    localparam int MAXW = MAX_BYTES * `SHRP_BYTE_BITS;

    initial begin
        if (MAX_BYTES < 1 || MAX_BYTES > (1 << `SHRP_WCODE_BITS)) begin
            $error("MAX_BYTES must lie between 1 and 4");
        end
        if (NUM_IRQ < 1) begin
            $error("NUM_IRQ must be at least 1");
        end
        if (WR_LATENCY_CYC < `SHRP_SYNC_CYCLES) begin
            $error("WR_LATENCY_CYC shorter than the crossing latency");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State types

    typedef struct packed {
        shrp_phase_t                     phase;
        logic [`SHRP_CNT_BITS-1:0]       bitcnt;
        logic [MAXW-1:0]                 shift;
        logic [`SHRP_WCODE_BITS-1:0]     wcode;
        logic                            stream;
    } shrp_frame_t;

    typedef struct packed {
        logic [`SHRP_ADDR_BITS-1:0]      addr;
        logic [`SHRP_WCODE_BITS-1:0]     wcode;
        logic [MAXW-1:0]                 wr_word;
        logic [`SHRP_NUM_XING-1:0]       tgl;
    } shrp_xfer_t;

    typedef struct packed {
        logic                            oe;
        logic                            sel_hold;
        logic [MAXW-1:0]                 shift;
    } shrp_tx_t;

    typedef struct packed {
        logic [MAXW-1:0]                 hold;
        logic [`SHRP_ADDR_BITS-1:0]      addr;
        logic [`SHRP_WCODE_BITS-1:0]     wcode;
        logic [MAXW-1:0]                 wdata;
        logic                            wr_stb;
        logic                            cmd_stb;
        logic                            rd_stb;
        logic                            irq;
        logic                            sel_s1;
        logic                            sel_s2;
        logic                            sel_s3;
    } shrp_core_t;

    localparam shrp_frame_t FRAME_RESET = '{phase: SHRP_PH_ADDR, default: '0};

    shrp_frame_t fr_reg;
    shrp_frame_t fr_next;
    shrp_xfer_t  xf_reg;
    shrp_xfer_t  xf_next;
    shrp_tx_t    tx_reg;
    shrp_tx_t    tx_next;
    shrp_core_t  co_reg;
    shrp_core_t  co_next;

    ////////////////////////////////////////////////////////////////////////
    // Register map lookups

    function automatic logic [`SHRP_WCODE_BITS-1:0] wcode_of(
        input logic [`SHRP_ADDR_BITS-1:0] a
    );
        logic [`SHRP_WCODE_BITS-1:0] c;
        c = WIDTH_MAP[int'(a) * `SHRP_WCODE_BITS +: `SHRP_WCODE_BITS];
        // Widths beyond the built word size are clamped
        if (int'(c) >= MAX_BYTES) begin
            c = `SHRP_WCODE_BITS'(MAX_BYTES - 1);
        end
        return c;
    endfunction

    function automatic logic [`SHRP_CNT_BITS-1:0] last_bit(
        input logic [`SHRP_WCODE_BITS-1:0] c
    );
        return `SHRP_CNT_BITS'((int'(c) + 1) * `SHRP_BYTE_BITS - 1);
    endfunction

    function automatic logic [MAXW-1:0] width_mask(
        input logic [`SHRP_WCODE_BITS-1:0] c
    );
        return {MAXW{1'b1}} >> (MAXW - (int'(c) + 1) * `SHRP_BYTE_BITS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Link domain, rising edge: framing and command data capture

    always_comb begin
        logic [MAXW-1:0]            sh;
        logic [`SHRP_ADDR_BITS-1:0] a;
        logic                       at_last;
        fr_next = fr_reg;
        xf_next = xf_reg;
        sh      = {fr_reg.shift[MAXW-2:0], command_data_in};
        a       = sh[`SHRP_ADDR_BITS-1:0];
        at_last = (fr_reg.bitcnt == last_bit(fr_reg.wcode));
        fr_next.shift = sh;
        case (fr_reg.phase)
            SHRP_PH_ADDR: begin
                if (fr_reg.bitcnt == `SHRP_CNT_BITS'(`SHRP_ADDR_BITS - 1)) begin
                    xf_next.addr   = a;
                    xf_next.wcode  = wcode_of(a);
                    fr_next.wcode  = wcode_of(a);
                    fr_next.stream = STREAM_MAP[a];
                    fr_next.bitcnt = '0;
                    if (CMD_MAP[a]) begin
                        xf_next.tgl[`SHRP_XING_CMD] = ~xf_reg.tgl[`SHRP_XING_CMD];
                        fr_next.phase = SHRP_PH_DONE;
                    end else if (RD_MAP[a]) begin
                        xf_next.tgl[`SHRP_XING_RD] = ~xf_reg.tgl[`SHRP_XING_RD];
                        fr_next.phase = SHRP_PH_READ;
                    end else begin
                        fr_next.phase = SHRP_PH_WRITE;
                    end
                end else begin
                    fr_next.bitcnt = fr_reg.bitcnt + `SHRP_CNT_BITS'(1);
                end
            end
            SHRP_PH_WRITE: begin
                if (at_last) begin
                    xf_next.wr_word = sh & width_mask(fr_reg.wcode);
                    xf_next.tgl[`SHRP_XING_WR] = ~xf_reg.tgl[`SHRP_XING_WR];
                    fr_next.bitcnt = '0;
                    // Streaming keeps taking words until select rises
                    if (!fr_reg.stream) begin
                        fr_next.phase = SHRP_PH_DONE;
                    end
                end else begin
                    fr_next.bitcnt = fr_reg.bitcnt + `SHRP_CNT_BITS'(1);
                end
            end
            SHRP_PH_READ: begin
                if (at_last) begin
                    fr_next.bitcnt = '0;
                    // Streaming fetches the next word at every word end, so the frame's last word end pops one unsent word
                    if (fr_reg.stream) begin
                        xf_next.tgl[`SHRP_XING_RD] = ~xf_reg.tgl[`SHRP_XING_RD];
                    end else begin
                        fr_next.phase = SHRP_PH_DONE;
                    end
                end else begin
                    fr_next.bitcnt = fr_reg.bitcnt + `SHRP_CNT_BITS'(1);
                end
            end
            SHRP_PH_DONE: begin
                fr_next.bitcnt = fr_reg.bitcnt;
            end
            default: begin
                fr_next.phase = SHRP_PH_DONE;
            end
        endcase
    end

    // Select high ends the frame at once; a partial word is dropped
    always_ff @(posedge link_sclk or posedge select_n or posedge rst) begin
        if (rst || select_n) begin
            fr_reg <= FRAME_RESET;
        end else begin
            fr_reg <= fr_next;
        end
    end

    // Kept across frames so the core can still pick up the last word
    always_ff @(posedge link_sclk or posedge rst) begin
        if (rst) begin
            xf_reg <= '0;
        end else begin
            xf_reg <= xf_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain, falling edge: reply shifter

    always_comb begin
        tx_next = tx_reg;
        if (fr_reg.phase == SHRP_PH_READ && fr_reg.bitcnt == '0) begin
            tx_next.oe       = 1'b1;
            tx_next.sel_hold = 1'b1;
        end else if (fr_reg.phase == SHRP_PH_READ && tx_reg.sel_hold) begin
            tx_next.shift    = co_reg.hold << 1;
            tx_next.sel_hold = 1'b0;
        end else begin
            tx_next.shift = tx_reg.shift << 1;
            if (fr_reg.phase != SHRP_PH_READ) begin
                tx_next.oe = 1'b0;
            end
        end
    end

    // Falling edge launch keeps each bit steady across the high phase
    always_ff @(negedge link_sclk or posedge select_n or posedge rst) begin
        if (rst || select_n) begin
            tx_reg <= '0;
        end else begin
            tx_reg <= tx_next;
        end
    end

    // First bit comes straight from the hold word to save half a period
    assign reply_data_out = tx_reg.sel_hold ? co_reg.hold[MAXW-1] : tx_reg.shift[MAXW-1];
    assign reply_data_oe  = tx_reg.oe;

    ////////////////////////////////////////////////////////////////////////
    // Domain crossing

    shrp_xing_if #(.N(`SHRP_NUM_XING)) xing ();

    assign xing.tgl = xf_reg.tgl;

    shrp_tsync #(
        .N (`SHRP_NUM_XING)
    ) u_tsync (
        .clk  (clk),
        .rst  (rst),
        .xing (xing)
    );

    ////////////////////////////////////////////////////////////////////////
    // Core domain: register access strobes, read hold, interrupt

    always_comb begin
        co_next         = co_reg;
        co_next.wr_stb  = 1'b0;
        co_next.cmd_stb = 1'b0;
        co_next.rd_stb  = 1'b0;
        co_next.sel_s1  = select_n;
        co_next.sel_s2  = co_reg.sel_s1;
        co_next.sel_s3  = co_reg.sel_s2;
        // Link words are stable for a whole word time once a toggle lands
        if (xing.pulse[`SHRP_XING_WR]) begin
            co_next.addr   = xf_reg.addr;
            co_next.wcode  = xf_reg.wcode;
            co_next.wdata  = xf_reg.wr_word;
            co_next.wr_stb = 1'b1;
        end
        if (xing.pulse[`SHRP_XING_CMD]) begin
            co_next.addr    = xf_reg.addr;
            co_next.wcode   = xf_reg.wcode;
            co_next.cmd_stb = 1'b1;
        end
        if (xing.pulse[`SHRP_XING_RD]) begin
            co_next.addr   = xf_reg.addr;
            co_next.wcode  = xf_reg.wcode;
            co_next.rd_stb = 1'b1;
        end
        // Answer taken in the strobe cycle, left aligned for the shifter
        if (co_reg.rd_stb) begin
            co_next.hold = (rd_data & width_mask(co_reg.wcode))
                           << (MAXW - (int'(co_reg.wcode) + 1) * `SHRP_BYTE_BITS);
        end
        co_next.irq = |(irq_sources & irq_mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            co_reg <= '{sel_s1: 1'b1, sel_s2: 1'b1, sel_s3: 1'b1, default: '0};
        end else begin
            co_reg <= co_next;
        end
    end

    // Open drain request: pulled low only while a masked-in source is set
    assign irq_n_out    = 1'b0;
    assign irq_n_oe     = co_reg.irq;
    assign reg_addr     = co_reg.addr;
    assign reg_bytes_m1 = co_reg.wcode;
    assign wr_data      = co_reg.wdata;
    assign wr_strobe    = co_reg.wr_stb;
    assign cmd_strobe   = co_reg.cmd_stb;
    assign rd_strobe    = co_reg.rd_stb;
    assign frame_active = ~co_reg.sel_s2;
    assign frame_end    = co_reg.sel_s2 & ~co_reg.sel_s3;

endmodule

`default_nettype wire

// >>> hw/dummy_never_used_placeholder_removed.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> verif/shrp_port_monitor.sv
// Concurrent checks on the serial host register port, bound to shrp_port.
// Assumes the core clock domain and the host serial clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "shrp_defs.svh"

module shrp_port_monitor
    import shrp_pkg::*;
#(
    parameter int         MAX_BYTES = 4,
    parameter int         NUM_IRQ   = 8,
    parameter bit [255:0] RD_MAP    = `SHRP_MAP_RESET,
    parameter bit [255:0] CMD_MAP   = `SHRP_MAP_RESET,
    parameter bit [511:0] WIDTH_MAP = {`SHRP_MAP_RESET, `SHRP_MAP_RESET}
) (
    input wire logic                               clk,
    input wire logic                               rst,
    input wire logic                               link_sclk,
    input wire logic                               select_n,
    input wire logic                               reply_data_out,
    input wire logic                               reply_data_oe,
    input wire logic                               irq_n_out,
    input wire logic                               irq_n_oe,
    input wire logic [`SHRP_ADDR_BITS-1:0]         reg_addr,
    input wire logic [`SHRP_WCODE_BITS-1:0]        reg_bytes_m1,
    input wire logic [MAX_BYTES*`SHRP_BYTE_BITS-1:0] wr_data,
    input wire logic                               wr_strobe,
    input wire logic                               cmd_strobe,
    input wire logic                               rd_strobe,
    input wire logic [NUM_IRQ-1:0]                 irq_sources,
    input wire logic [NUM_IRQ-1:0]                 irq_mask
);
    logic rise_bit_reg;
    logic any_stb;

    assign any_stb = wr_strobe | cmd_strobe | rd_strobe;

    ////////////////////////////////////////////////////////////
    // Level the host saw at the last rise, compared at the fall
    always_ff @(posedge link_sclk) begin
        rise_bit_reg <= reply_data_out;
    end

    a_strobe_alone: assert property (@(posedge clk) disable iff (rst)
        $onehot0({wr_strobe, cmd_strobe, rd_strobe})) else $error("strobes overlap");
    a_strobe_pulse: assert property (@(posedge clk) disable iff (rst)
        any_stb |=> !any_stb) else $error("strobe longer than one cycle");
    a_wr_decode: assert property (@(posedge clk) disable iff (rst)
        wr_strobe |-> !RD_MAP[reg_addr] && !CMD_MAP[reg_addr]) else $error("bad write");
    a_rd_decode: assert property (@(posedge clk) disable iff (rst)
        rd_strobe |-> RD_MAP[reg_addr] && !CMD_MAP[reg_addr]) else $error("bad read");
    a_cmd_decode: assert property (@(posedge clk) disable iff (rst)
        cmd_strobe |-> CMD_MAP[reg_addr]) else $error("bad command");
    a_word_width: assert property (@(posedge clk) disable iff (rst)
        (wr_strobe || rd_strobe) |-> reg_bytes_m1 == WIDTH_MAP[2*reg_addr +: 2])
        else $error("word width wrong");
    a_wr_upper_zero: assert property (@(posedge clk) disable iff (rst)
        wr_strobe |-> (wr_data >> (8*(reg_bytes_m1+1))) == '0) else $error("wide write");
    a_irq_masked: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> irq_n_oe == $past(|(irq_sources & irq_mask)) && !irq_n_out)
        else $error("interrupt not per mask");
    a_oe_idle: assert property (@(posedge clk) disable iff (rst)
        (select_n || wr_strobe || cmd_strobe) |-> !reply_data_oe)
        else $error("reply driven outside read");
    a_reply_stable: assert property (@(negedge link_sclk) disable iff (rst)
        reply_data_oe |-> reply_data_out == rise_bit_reg) else $error("reply moved");
endmodule

`default_nettype wire

// >>> verif/shrp_host_model.sv
// Host serial master model: frames, clocks and shifts bits.
// Assumes the caller starts each frame just after a core clock fall.
`timescale 1ns/1ps
`default_nettype none

module shrp_host_model (
    output logic      link_sclk,
    output logic      select_n,
    output logic      command_data_in,
    input  wire logic reply_data_out,
    input  wire logic reply_data_oe
);
    wire line = reply_data_oe ? reply_data_out : 1'bz;

    initial begin
        link_sclk = 1'b0;
        select_n = 1'b1;
        command_data_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////
    // Serial clock runs only inside a frame; 2 ns skew keeps edges off core rises
    task automatic frame(input logic [31:0] tx, input int n,
                         output logic [31:0] rx, output logic oe_any);
        rx = '0;
        oe_any = 1'b0;
        #2 select_n = 1'b0;
        #24;
        for (int i = n - 1; i >= 0; i--) begin
            command_data_in = tx[i];
            #24 link_sclk = 1'b1;
            rx = {rx[30:0], line};
            oe_any = oe_any | (reply_data_oe === 1'b1);
            #24 link_sclk = 1'b0;
        end
        #24 select_n = 1'b1;
        command_data_in = ~command_data_in;
        #100;
    endtask
endmodule

`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for shrp_port with a host model on the serial side.
// Assumes the monitor and host model files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "shrp_defs.svh"

`define SHRP_CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("MISMATCH at %0t got %0h exp %0h", $time, got, exp); \
        end \
    end

module tb_top
    import shrp_pkg::*;
;
    localparam bit [255:0] RDM = (256'h1 << 8'h20) | (256'h1 << 8'h50);
    localparam bit [255:0] CMDM = 256'h1 << 8'h30;
    localparam bit [255:0] STRM = (256'h1 << 8'h40) | (256'h1 << 8'h50);
    localparam bit [511:0] WIDM = 512'h1 << 8'h40;

    logic        clk, rst, link_sclk, select_n, command_data_in;
    logic        reply_data_out, reply_data_oe, irq_n_out, irq_n_oe;
    logic        wr_strobe, cmd_strobe, rd_strobe, frame_active, frame_end;
    logic [7:0]  reg_addr, irq_sources, irq_mask;
    logic [1:0]  reg_bytes_m1;
    logic [31:0] wr_data, rx;
    logic [31:0] rd_data = 32'h0;
    logic [31:0] rd_cnt = 32'h0;
    logic [23:0] wr_hist = 24'h0;
    logic        oe_any;
    int          wr_cnt = 0;
    int          cmd_cnt = 0;
    int          fend_cnt = 0;
    int          fa_cnt = 0;
    int          bad_count = 0;
    int          total_checks = 0;

    shrp_port #(.RD_MAP(RDM), .CMD_MAP(CMDM), .STREAM_MAP(STRM), .WIDTH_MAP(WIDM)) u_dut (
        .clk(clk), .rst(rst), .link_sclk(link_sclk), .select_n(select_n),
        .command_data_in(command_data_in), .reply_data_out(reply_data_out),
        .reply_data_oe(reply_data_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
        .reg_addr(reg_addr), .reg_bytes_m1(reg_bytes_m1), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .cmd_strobe(cmd_strobe), .rd_strobe(rd_strobe),
        .rd_data(rd_data), .irq_sources(irq_sources), .irq_mask(irq_mask),
        .frame_active(frame_active), .frame_end(frame_end));

    shrp_host_model u_host (.link_sclk(link_sclk), .select_n(select_n),
        .command_data_in(command_data_in), .reply_data_out(reply_data_out),
        .reply_data_oe(reply_data_oe));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////
    // Strobe bookkeeping; read word k answers 0xC3E0 + k
    always @(posedge clk) begin
        if (wr_strobe === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            wr_hist <= {wr_hist[15:0], wr_data[7:0]};
        end
        if (rd_strobe === 1'b1) begin
            rd_cnt <= rd_cnt + 32'h1;
        end
        if (cmd_strobe === 1'b1) begin
            cmd_cnt <= cmd_cnt + 1;
        end
        // Frame tracking seen from the core side
        if (frame_end === 1'b1) begin
            fend_cnt <= fend_cnt + 1;
        end
        if (frame_active === 1'b1) begin
            fa_cnt <= fa_cnt + 1;
        end
    end

    always @(negedge clk) begin
        rd_data <= 32'h0000C3E0 + rd_cnt;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic xfer(input logic [31:0] tx, input int n);
        @(negedge clk);
        u_host.frame(tx, n, rx, oe_any);
    endtask

    task automatic t_write();
        int w0;
        int a0;
        int f0;
        w0 = wr_cnt;
        a0 = fa_cnt;
        f0 = fend_cnt;
        xfer(32'h000010A5, 16);
        `SHRP_CHK(wr_cnt - w0, 1)
        `SHRP_CHK(reg_addr, 8'h10)
        `SHRP_CHK(wr_data, 32'h000000A5)
        `SHRP_CHK(oe_any, 1'b0)
        // Select low 816 ns from a clock fall covers 82 core rises
        `SHRP_CHK(fa_cnt - a0, 82)
        `SHRP_CHK(fend_cnt - f0, 1)
        `SHRP_CHK(frame_active, 1'b0)
        $display("test write done");
    endtask

    task automatic t_read();
        logic [31:0] k;
        k = rd_cnt;
        xfer(32'h00200000, 24);
        `SHRP_CHK(rx[15:0], 16'hC3E0 + k[15:0])
        `SHRP_CHK(reg_bytes_m1, 2'h1)
        `SHRP_CHK(oe_any, 1'b1)
        $display("test read done");
    endtask

    task automatic t_cmd();
        int c0;
        int w0;
        c0 = cmd_cnt;
        w0 = wr_cnt;
        xfer(32'h00000030, 8);
        `SHRP_CHK(cmd_cnt - c0, 1)
        `SHRP_CHK(wr_cnt - w0, 0)
        `SHRP_CHK(reg_addr, 8'h30)
        $display("test command done");
    endtask

    task automatic t_streams();
        int w0;
        logic [31:0] k;
        logic [15:0] exp16;
        w0 = wr_cnt;
        xfer(32'h40112233, 32);
        `SHRP_CHK(wr_cnt - w0, 3)
        `SHRP_CHK(wr_hist, 24'h112233)
        k = rd_cnt;
        exp16 = {8'hE0 + k[7:0], 8'hE1 + k[7:0]};
        xfer(32'h00500000, 24);
        `SHRP_CHK(rx[15:0], exp16)
        $display("test streaming done");
    endtask

    task automatic t_refuse();
        int w0;
        w0 = wr_cnt;
        xfer(32'h00000107, 12);
        `SHRP_CHK(wr_cnt - w0, 0)
        xfer(32'h00105AFF, 24);
        `SHRP_CHK(wr_cnt - w0, 1)
        `SHRP_CHK(wr_data, 32'h0000005A)
        $display("test refuse done");
    endtask

    task automatic t_irq();
        logic [31:0] k;
        @(negedge clk);
        irq_sources = 8'h05;
        irq_mask = 8'h04;
        repeat (2) @(negedge clk);
        `SHRP_CHK(irq_n_oe, 1'b1)
        irq_mask = 8'h0A;
        repeat (2) @(negedge clk);
        `SHRP_CHK(irq_n_oe, 1'b0)
        irq_sources = 8'h08;
        repeat (2) @(negedge clk);
        `SHRP_CHK(irq_n_oe, 1'b1)
        `SHRP_CHK(irq_n_out, 1'b0)
        // Host answers the request by reading status over the port
        k = rd_cnt;
        xfer(32'h00200000, 24);
        `SHRP_CHK(rx[15:0], 16'hC3E0 + k[15:0])
        $display("test interrupt done");
    endtask

    initial begin
        rst = 1'b1;
        irq_sources = 8'h00;
        irq_mask = 8'h00;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (5) @(negedge clk);
        t_write();
        t_read();
        t_cmd();
        t_streams();
        t_refuse();
        t_irq();
        give_verdict();
    end

    // Tests need about 9 us; a generous multiple guards against a hang
    initial begin
        #200000;
        bad_count++;
        give_verdict();
    end
endmodule

bind shrp_port shrp_port_monitor #(.MAX_BYTES(MAX_BYTES), .NUM_IRQ(NUM_IRQ),
    .RD_MAP(RD_MAP), .CMD_MAP(CMD_MAP), .WIDTH_MAP(WIDTH_MAP)) u_mon (
    .clk(clk), .rst(rst), .link_sclk(link_sclk), .select_n(select_n),
    .reply_data_out(reply_data_out), .reply_data_oe(reply_data_oe),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .reg_addr(reg_addr),
    .reg_bytes_m1(reg_bytes_m1), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .cmd_strobe(cmd_strobe), .rd_strobe(rd_strobe), .irq_sources(irq_sources),
    .irq_mask(irq_mask));

`default_nettype wire
